// ==== verilog/crqd_framer.sv ====
// completer request framer: builds the 128-bit descriptor and streams it ahead of the payload
// Contract
// R1: every packet opens with a 128-bit descriptor; payload follows only when present.
// R2: attributes sit at 126:124: no-snoop 124, relaxed ordering 125, ID ordering 126.
// R3: ID-based ordering bit passes only for memory requests and messages; the framer also passes it for I/O requests (codes 0010, 0011).
// R4: user keeps attributes of non-posted requests and returns them with completion.
// R5: user keeps traffic class 123:121 of non-posted requests for the completion.
// R6: latency report messages carry snoop latency in bits 15:0.
// R7: latency report messages carry no-snoop latency in bits 31:16.
// R8: flush hint messages carry 4-bit code in 35:32; 1111, 0001, 0000 defined.
// R9: every message carries its 8-bit message code in bits 111:104.
// R10: every message carries its 3-bit routing field in bits 114:112.
// R11: vendor messages routed by ID (010) carry destination ID in 15:0.
// R12: vendor messages carry header doubleword 3 in bits 63:32.
// R13: translation messages carry header doublewords 2 and 3 in bits 63:0.
// R14: request type codes 0000..0110 name memory, I/O and atomic requests.
// R15: code 0111 is a locked read, allowed only in legacy mode.
// R16: configuration codes 1000..1011 never appear on the completer stream.
// R17: 1100 plain message, 1101 vendor, 1110 translation, 1111 reserved.
// R18: user decodes message fields only after checking type and message code.
`timescale 1ns/1ps
`include "crqd_cfg.svh"

module crqd_framer #(
    parameter int DATA_W = `CRQD_DESC_W,
    parameter logic [7:0] LTR_CODE = `CRQD_LTR_CODE,
    parameter logic [7:0] OBFF_CODE = `CRQD_OBFF_CODE
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic legacy_mode,
    input wire logic hdr_valid,
    output logic hdr_ready,
    input wire logic [3:0] hdr_type,
    input wire logic [2:0] hdr_attr,
    input wire logic [2:0] hdr_tc,
    input wire logic [7:0] hdr_msg_code,
    input wire logic [2:0] hdr_msg_route,
    input wire logic [31:0] hdr_dw2,
    input wire logic [31:0] hdr_dw3,
    input wire logic [`CRQD_BASE_HI:0] hdr_base,
    input wire logic hdr_has_payload,
    input wire logic pay_valid,
    output logic pay_ready,
    input wire logic [DATA_W-1:0] pay_data,
    input wire logic pay_last,
    output logic [DATA_W-1:0] cq_tdata,
    output logic cq_tvalid,
    input wire logic cq_tready,
    output logic cq_tlast,
    output logic cq_sop,
    output logic drop_pulse
);

    // buffer word: {sop, last, data}
    localparam int WORD_W = DATA_W + 2;

    crqd_pkg::crqd_state_t state_r;
    crqd_pkg::crqd_state_t state_nxt;
    logic hdr_ready_r;
    logic pay_ready_r;
    logic drop_r;
    logic [WORD_W-1:0] out_r;
    logic out_valid_r;
    logic [WORD_W-1:0] skid_r;
    logic skid_valid_r;
    logic skid_valid_nxt;

    // type decode
    wire logic is_mem = hdr_type <= crqd_pkg::RT_CAS; // [R14]
    wire logic is_lock = hdr_type == crqd_pkg::RT_LOCK_RD; // [R15]
    wire logic is_cfg = hdr_type inside {crqd_pkg::RT_CFG0_RD, crqd_pkg::RT_CFG1_RD,
        crqd_pkg::RT_CFG0_WR, crqd_pkg::RT_CFG1_WR}; // [R16]
    wire logic is_gmsg = hdr_type == crqd_pkg::RT_MSG; // [R17]
    wire logic is_vend = hdr_type == crqd_pkg::RT_MSG_VEND; // [R17]
    wire logic is_ats = hdr_type == crqd_pkg::RT_MSG_ATS; // [R17]
    wire logic is_rsvd = hdr_type == crqd_pkg::RT_RSVD; // [R17]
    wire logic is_msg = is_gmsg | is_vend | is_ats;
    wire logic is_ltr = is_gmsg && (hdr_msg_code == LTR_CODE);
    wire logic is_obff = is_gmsg && (hdr_msg_code == OBFF_CODE);
    // requests that must not reach the completer user logic are swallowed
    wire logic bad_req = is_cfg | is_rsvd | (is_lock & ~legacy_mode); // [R15] [R16]

    // attribute field; ID ordering forced clear outside request codes 0000..0110 (memory, I/O, atomic) and messages
    wire logic ido_ok = is_mem | is_msg; // [R3]
    wire logic [2:0] attr_eff = {hdr_attr[`CRQD_ATTR_IDO] & ido_ok,
        hdr_attr[`CRQD_ATTR_RO], hdr_attr[`CRQD_ATTR_NS]}; // [R2] [R3]

    // message-specific low 64 bits
    wire logic [15:0] ltr_snoop = hdr_dw3[15:0];
    wire logic [15:0] ltr_nosnoop = hdr_dw3[31:16];
    wire logic [3:0] obff_code = hdr_dw3[3:0];
    wire logic by_id = hdr_msg_route == `CRQD_ROUTE_BY_ID;
    wire logic [15:0] dest_id = by_id ? hdr_dw2[31:16] : 16'h0000; // [R11]
    wire logic [63:0] ltr_low = {32'h0000_0000, ltr_nosnoop, ltr_snoop}; // [R6] [R7]
    wire logic [63:0] obff_low = {28'h000_0000, obff_code, 32'h0000_0000}; // [R8]
    wire logic [63:0] vend_low = {hdr_dw3, 16'h0000, dest_id}; // [R11] [R12]
    wire logic [63:0] ats_low = {hdr_dw3, hdr_dw2}; // [R13]
    wire logic [63:0] msg_low = is_ats ? ats_low :
        is_vend ? vend_low :
        is_ltr ? ltr_low :
        is_obff ? obff_low : 64'h0000_0000_0000_0000;

    // fields below the class: messages get code, routing and their own low word
    wire logic [`CRQD_BASE_HI:0] msg_base = {hdr_base[`CRQD_BASE_HI:`CRQD_APER_LO],
        hdr_msg_route, hdr_msg_code, hdr_base[`CRQD_MID_HI:`CRQD_MID_LO], msg_low}; // [R9] [R10]
    wire logic [`CRQD_BASE_HI:0] body = is_msg ? msg_base : hdr_base;
    wire logic [`CRQD_DESC_W-1:0] desc = {1'b0, attr_eff, hdr_tc, body}; // [R2] [R5]
    wire logic [DATA_W-1:0] desc_word = DATA_W'(desc);

    // handshakes
    wire logic hdr_acc = ce & hdr_valid & hdr_ready_r;
    wire logic pay_acc = ce & pay_valid & pay_ready_r;
    wire logic push_desc = hdr_acc & ~bad_req; // [R1]
    wire logic push_pay = pay_acc & (state_r == crqd_pkg::ST_PAY); // [R1]
    wire logic push = push_desc | push_pay;
    // descriptor is last only when no payload follows
    wire logic in_last = push_desc ? ~hdr_has_payload : pay_last; // [R1]
    wire logic [WORD_W-1:0] in_word = push_desc ? {1'b1, in_last, desc_word} :
        {1'b0, in_last, pay_data};
    wire logic out_fire = ce & out_valid_r & cq_tready;
    wire logic out_free = ~out_valid_r | out_fire;

    // state sequencing
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            crqd_pkg::ST_IDLE: begin
                if (hdr_acc && hdr_has_payload) begin
                    state_nxt = bad_req ? crqd_pkg::ST_DROP : crqd_pkg::ST_PAY;
                end
            end
            crqd_pkg::ST_PAY: begin
                if (pay_acc && pay_last) begin
                    state_nxt = crqd_pkg::ST_IDLE;
                end
            end
            crqd_pkg::ST_DROP: begin
                if (pay_acc && pay_last) begin
                    state_nxt = crqd_pkg::ST_IDLE;
                end
            end
            default: begin
                state_nxt = crqd_pkg::ST_IDLE;
            end
        endcase
    end

    // skid entry holds a word only while the output stage is blocked
    assign skid_valid_nxt = skid_valid_r ? ~out_free : (push & ~out_free);

    // readiness registered so both ready outputs come from flops
    wire logic hdr_ready_nxt = (state_nxt == crqd_pkg::ST_IDLE) & ~skid_valid_nxt;
    wire logic pay_ready_nxt = (state_nxt == crqd_pkg::ST_DROP) |
        ((state_nxt == crqd_pkg::ST_PAY) & ~skid_valid_nxt);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r <= crqd_pkg::ST_IDLE;
            hdr_ready_r <= 1'b0;
            pay_ready_r <= 1'b0;
            drop_r <= 1'b0;
        end else if (ce) begin
            state_r <= state_nxt;
            hdr_ready_r <= hdr_ready_nxt;
            pay_ready_r <= pay_ready_nxt;
            drop_r <= hdr_acc & bad_req; // [R16]
        end
    end

    // two-entry buffer: output stage plus skid, so a stalled receiver loses no word
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            out_r <= {2'b00, `CRQD_RST_DATA};
            out_valid_r <= 1'b0;
            skid_r <= {2'b00, `CRQD_RST_DATA};
            skid_valid_r <= 1'b0;
        end else if (ce) begin
            skid_valid_r <= skid_valid_nxt;
            if (out_free) begin
                out_valid_r <= skid_valid_r | push;
                out_r <= skid_valid_r ? skid_r : in_word;
            end else if (push) begin
                skid_r <= in_word;
            end
        end
    end

    assign hdr_ready = hdr_ready_r;
    assign pay_ready = pay_ready_r;
    assign drop_pulse = drop_r;
    assign cq_tvalid = out_valid_r;
    assign cq_tdata = out_r[DATA_W-1:0];
    assign cq_tlast = out_r[DATA_W];
    assign cq_sop = out_r[DATA_W+1];

endmodule : crqd_framer

// ==== verilog/crqd_cfg.svh ====
// bit positions, codes and reset values of the completer request descriptor framer
`ifndef CRQD_CFG_SVH
`define CRQD_CFG_SVH

`define CRQD_DESC_W 128
`define CRQD_ATTR_HI 126
`define CRQD_ATTR_LO 124
`define CRQD_ATTR_NS 0
`define CRQD_ATTR_RO 1
`define CRQD_ATTR_IDO 2
`define CRQD_TC_HI 123
`define CRQD_TC_LO 121
`define CRQD_BASE_HI 120
`define CRQD_APER_LO 115
`define CRQD_ROUTE_HI 114
`define CRQD_ROUTE_LO 112
`define CRQD_CODE_HI 111
`define CRQD_CODE_LO 104
`define CRQD_MID_HI 103
`define CRQD_MID_LO 64
`define CRQD_ROUTE_BY_ID 3'h2
`define CRQD_LTR_CODE 8'h10
`define CRQD_OBFF_CODE 8'h12
`define CRQD_OBFF_CPU 4'hF
`define CRQD_OBFF_AVAIL 4'h1
`define CRQD_OBFF_IDLE 4'h0
`define CRQD_RST_DATA 128'h0

`endif

// ==== verilog/crqd_pkg.sv ====
// types shared by the completer request descriptor framer
package crqd_pkg;

    typedef enum logic [3:0] {
        RT_MEM_RD = 4'h0,
        RT_MEM_WR = 4'h1,
        RT_IO_RD = 4'h2,
        RT_IO_WR = 4'h3,
        RT_FETCH_ADD = 4'h4,
        RT_SWAP = 4'h5,
        RT_CAS = 4'h6,
        RT_LOCK_RD = 4'h7,
        RT_CFG0_RD = 4'h8,
        RT_CFG1_RD = 4'h9,
        RT_CFG0_WR = 4'hA,
        RT_CFG1_WR = 4'hB,
        RT_MSG = 4'hC,
        RT_MSG_VEND = 4'hD,
        RT_MSG_ATS = 4'hE,
        RT_RSVD = 4'hF
    } crqd_req_type_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PAY = 2'b01,
        ST_DROP = 2'b10
    } crqd_state_t;

endpackage : crqd_pkg

// ==== test/crqd_framer_assertions.sv ====
// port-level checks for the descriptor framer
`timescale 1ns/1ps
module crqd_framer_chk #(parameter int DATA_W = 128) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic legacy_mode,
    input wire logic hdr_valid,
    input wire logic hdr_ready,
    input wire logic [3:0] hdr_type,
    input wire logic hdr_has_payload,
    input wire logic pay_valid,
    input wire logic pay_ready,
    input wire logic pay_last,
    input wire logic [DATA_W-1:0] cq_tdata,
    input wire logic cq_tvalid,
    input wire logic cq_tready,
    input wire logic cq_sop,
    input wire logic drop_pulse
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);
    wire logic take_h = hdr_valid && hdr_ready && ce;
    wire logic bad_h = hdr_type inside {[4'h8:4'hB], 4'hF} || (hdr_type == 4'h7 && !legacy_mode);
    refuse_drop_a: assert property (take_h && bad_h ##1 ce |-> drop_pulse)
        else $error("refused header without drop");
    lock_pass_a: assert property (take_h && hdr_type == 4'h7 && legacy_mode |=> !drop_pulse)
        else $error("legacy locked read dropped");
    req_out_a: assert property (take_h && !bad_h |-> ##[1:200] cq_tvalid && cq_sop)
        else $error("no descriptor beat");
    stall_hold_a: assert property (cq_tvalid && !(cq_tready && ce) |=> cq_tvalid && $stable(cq_tdata))
        else $error("beat changed while stalled");
    top_bit_a: assert property (cq_tvalid && cq_sop |-> !cq_tdata[127])
        else $error("descriptor bit 127 set");
    hdr_hold_a: assert property (take_h && hdr_has_payload |=> !hdr_ready)
        else $error("header ready during payload");
    pay_end_a: assert property (pay_valid && pay_ready && ce && pay_last |=> !pay_ready)
        else $error("payload ready after last beat");
    ce_freeze_a: assert property (!ce |=> $stable(cq_tvalid) && $stable(hdr_ready))
        else $error("state moved with enable low");
endmodule : crqd_framer_chk
bind crqd_framer crqd_framer_chk #(.DATA_W(DATA_W)) u_chk (.clk, .reset, .ce, .legacy_mode, .hdr_valid,
    .hdr_ready, .hdr_type, .hdr_has_payload, .pay_valid, .pay_ready, .pay_last, .cq_tdata, .cq_tvalid,
    .cq_tready, .cq_sop, .drop_pulse);

// ==== test/crqd_user_sink.sv ====
// user completer model: random back-pressure, keeps attributes for the completion
`timescale 1ns/1ps
module crqd_user_sink (
    input wire logic clk,
    input wire logic reset,
    input wire logic stall,
    input wire logic [127:0] cq_tdata,
    input wire logic cq_tvalid,
    input wire logic cq_sop,
    output logic cq_tready
);
    logic [5:0] cpl_attr_tc_r;
    initial cq_tready = 1'b0;
    always @(negedge clk) cq_tready <= !stall && ($urandom % 4 != 0);
    // type sits upstream here, so message fields stay undecoded
    always @(posedge clk) if (!reset && cq_tvalid && cq_tready && cq_sop) cpl_attr_tc_r <= cq_tdata[126:121];
endmodule : crqd_user_sink

// ==== test/completer_request_descriptor_fields_tb_top.sv ====
// self-checking bench: reference beats queued and compared at every output handshake
`timescale 1ns/1ps
module completer_request_descriptor_fields_tb_top;
    logic clk = 0, reset = 1, ce = 1, legacy_mode = 0, hdr_valid = 0, hdr_has_payload = 0, stall = 0;
    logic pay_valid = 0, pay_last = 0, hdr_ready, pay_ready, cq_tvalid, cq_tready, cq_tlast, cq_sop, drop_pulse;
    logic [3:0] hdr_type = 0;
    logic [2:0] hdr_attr = 0, hdr_tc = 0, hdr_msg_route = 0;
    logic [7:0] hdr_msg_code = 0;
    logic [31:0] hdr_dw2 = 0, hdr_dw3 = 0;
    logic [120:0] hdr_base = 0;
    logic [127:0] pay_data = 0, cq_tdata, d;
    logic [129:0] exp_q[$];
    logic [5:0] last_at = 0;
    int fails = 0, num_checks = 0, drops = 0, seen_drops = 0;
    always #10 clk = ~clk;
    crqd_framer u_dut (.clk, .reset, .ce, .legacy_mode, .hdr_valid, .hdr_ready, .hdr_type, .hdr_attr, .hdr_tc,
        .hdr_msg_code, .hdr_msg_route, .hdr_dw2, .hdr_dw3, .hdr_base, .hdr_has_payload, .pay_valid, .pay_ready,
        .pay_data, .pay_last, .cq_tdata, .cq_tvalid, .cq_tready, .cq_tlast, .cq_sop, .drop_pulse);
    crqd_user_sink u_sink (.clk, .reset, .stall, .cq_tdata, .cq_tvalid, .cq_sop, .cq_tready);
    task automatic chk(input string what, input logic [129:0] seen, input logic [129:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    // called at a falling edge, returns at the falling edge after the taking edge
    task automatic take(input bit pay);
        ce = ($urandom % 8) != 0;
        while (!(ce && (pay ? pay_ready : hdr_ready))) begin
            @(negedge clk);
            ce = ($urandom % 8) != 0;
        end
        @(negedge clk);
    endtask : take
    task automatic send(input logic [3:0] t, input logic lg);
        int nb;
        logic bad;
        hdr_valid = 1;
        hdr_type = t;
        legacy_mode = lg;
        {hdr_attr, hdr_tc, hdr_msg_route, hdr_has_payload} = 10'($urandom);
        hdr_msg_code = ($urandom % 2) ? {6'h4, 1'($urandom), 1'b0} : 8'($urandom);
        {hdr_dw2, hdr_dw3} = {$urandom, $urandom};
        hdr_base = 121'({$urandom, $urandom, $urandom, $urandom});
        d = {1'b0, hdr_attr, hdr_tc, hdr_base};
        if (!(t <= 4'h6 || t inside {[4'hC:4'hE]})) d[126] = 1'b0;
        if (t >= 4'hC) begin
            d[114:104] = {hdr_msg_route, hdr_msg_code};
            d[63:0] = (t == 4'hE) ? {hdr_dw3, hdr_dw2} : 64'h0;
            if (t == 4'hD) d[63:0] = {hdr_dw3, 16'h0, hdr_msg_route == 3'h2 ? hdr_dw2[31:16] : 16'h0};
            if (t == 4'hC && hdr_msg_code == 8'h10) d[31:0] = hdr_dw3;
            if (t == 4'hC && hdr_msg_code == 8'h12) d[35:32] = hdr_dw3[3:0];
        end
        bad = t inside {[4'h8:4'hB], 4'hF} || (t == 4'h7 && !lg);
        if (!bad) last_at = d[126:121];
        if (bad) drops++;
        else exp_q.push_back({1'b1, !hdr_has_payload, d});
        take(0);
        if (hdr_has_payload) begin
            hdr_valid = 0;
            pay_valid = 1;
            nb = 1 + $urandom % 3;
            for (int i = 1; i <= nb; i++) begin
                pay_data = {4{$urandom}};
                pay_last = i == nb;
                if (!bad) exp_q.push_back({1'b0, pay_last, pay_data});
                take(1);
            end
            pay_valid = 0;
        end
    endtask : send
    always @(posedge clk) begin
        if (!reset && ce && cq_tvalid && cq_tready) chk("cq beat", {cq_sop, cq_tlast, cq_tdata}, exp_q.size() ? exp_q.pop_front() : 'x);
        if (!reset && ce && drop_pulse) seen_drops++;
    end
    initial begin
        void'($urandom(56));
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk("reset outs", 130'({hdr_ready, pay_ready, cq_tvalid, cq_tlast, cq_sop, drop_pulse}), 130'h0);
        reset = 0;
        @(negedge clk);
        chk("ready after reset", 130'(hdr_ready), 130'h1);
        for (int k = 0; k < 32; k++) send(4'(k), 1'(k >> 4));
        stall = 1;
        // receiver holds off for a while so both buffer entries fill and the readies drop
        fork
            begin
                repeat (40) @(negedge clk);
                stall = 0;
            end
        join_none
        for (int k = 0; k < 300; k++) send(4'($urandom), 1'($urandom));
        hdr_valid = 0;
        @(negedge clk);
        ce = 1;
        repeat (40) @(negedge clk);
        chk("beats left", 130'(exp_q.size()), 130'h0);
        chk("drops", 130'(seen_drops), 130'(drops));
        chk("kept attr tc", 130'(u_sink.cpl_attr_tc_r), 130'(last_at));
        report_and_stop();
    end
    // several times the expected run length
    initial begin
        #400000;
        fails++;
        report_and_stop();
    end
endmodule : completer_request_descriptor_fields_tb_top
